// ---- hdt_pkg.sv ----
package hdt_pkg;

    // Address space of one read: the other-speed configuration set.
    localparam int          ADDR_W         = 6;
    localparam logic [5:0]  OFS_IF_STT     = 6'h09;
    localparam logic [5:0]  OFS_EP_STT     = 6'h12;
    localparam logic [5:0]  OFS_IF_MTT     = 6'h19;
    localparam logic [5:0]  OFS_EP_MTT     = 6'h22;
    localparam logic [5:0]  SET_END_STT    = 6'h19;
    localparam logic [5:0]  SET_END_MTT    = 6'h29;

    // Field offsets inside the configuration descriptor.
    localparam logic [5:0]  CFG_OFS_LEN    = 6'h00;
    localparam logic [5:0]  CFG_OFS_TYPE   = 6'h01;
    localparam logic [5:0]  CFG_OFS_TOT_LO = 6'h02;
    localparam logic [5:0]  CFG_OFS_TOT_HI = 6'h03;
    localparam logic [5:0]  CFG_OFS_NUMIF  = 6'h04;
    localparam logic [5:0]  CFG_OFS_VALUE  = 6'h05;
    localparam logic [5:0]  CFG_OFS_STRING = 6'h06;
    localparam logic [5:0]  CFG_OFS_ATTR   = 6'h07;
    localparam logic [5:0]  CFG_OFS_POWER  = 6'h08;

    // Field offsets inside interface and endpoint descriptors.
    localparam logic [5:0]  IF_OFS_LEN      = 6'h00;
    localparam logic [5:0]  IF_OFS_TYPE     = 6'h01;
    localparam logic [5:0]  IF_OFS_NUMBER   = 6'h02;
    localparam logic [5:0]  IF_OFS_NUM_EP   = 6'h04;
    localparam logic [5:0]  IF_OFS_CLASS    = 6'h05;
    localparam logic [5:0]  IF_OFS_SUBCLASS = 6'h06;
    localparam logic [5:0]  EP_OFS_LEN      = 6'h00;
    localparam logic [5:0]  EP_OFS_TYPE     = 6'h01;
    localparam logic [5:0]  EP_OFS_ADDR     = 6'h02;
    localparam logic [5:0]  EP_OFS_ATTR     = 6'h03;
    localparam logic [5:0]  IF_OFS_ALT     = 6'h03;
    localparam logic [5:0]  IF_OFS_PROTO   = 6'h07;
    localparam logic [5:0]  IF_OFS_STRING  = 6'h08;
    localparam logic [5:0]  EP_OFS_MPS_LO  = 6'h04;
    localparam logic [5:0]  EP_OFS_MPS_HI  = 6'h05;
    localparam logic [5:0]  EP_OFS_IVAL    = 6'h06;

    // Configuration descriptor values.
    localparam logic [7:0]  CFG_LEN        = 8'h09;
    localparam logic [7:0]  CFG_TYPE       = 8'h07;
    localparam logic [15:0] TOTAL_LEN_STT  = 16'h0019;
    localparam logic [15:0] TOTAL_LEN_MTT  = 16'h0029;
    localparam logic [7:0]  CFG_NUM_IF     = 8'h01;
    localparam logic [7:0]  CFG_VALUE      = 8'h01;
    localparam logic [7:0]  CFG_STRING     = 8'h00;
    localparam logic [7:0]  ATTR_BUS_PWR   = 8'ha0;
    localparam logic [7:0]  ATTR_SELF_PWR  = 8'he0;

    // Interface descriptor values.
    localparam logic [7:0]  IF_LEN         = 8'h09;
    localparam logic [7:0]  IF_TYPE        = 8'h04;
    localparam logic [7:0]  IF_NUMBER      = 8'h00;
    localparam logic [7:0]  IF_ALT_STT     = 8'h00;
    localparam logic [7:0]  IF_ALT_MTT     = 8'h01;
    localparam logic [7:0]  IF_NUM_EP      = 8'h01;
    localparam logic [7:0]  IF_CLASS       = 8'h09;
    localparam logic [7:0]  IF_SUBCLASS    = 8'h00;
    localparam logic [7:0]  IF_PROTO_ONE   = 8'h00;
    localparam logic [7:0]  IF_PROTO_TWO   = 8'h01;
    localparam logic [7:0]  IF_PROTO_MTT   = 8'h02;
    localparam logic [7:0]  IF_STRING      = 8'h00;

    // Status change endpoint descriptor values.
    localparam logic [7:0]  EP_LEN         = 8'h07;
    localparam logic [7:0]  EP_TYPE        = 8'h05;
    localparam logic [7:0]  EP_ADDR        = 8'h81;
    localparam logic [7:0]  EP_ATTR        = 8'h03;
    localparam logic [15:0] EP_MPS         = 16'h0001;
    localparam logic [7:0]  EP_IVAL_HS     = 8'h0c;

    localparam logic [7:0]  BYTE_NONE      = 8'h00;

endpackage

// ---- hdt_desc_tables.sv ----
// Notes on behaviour
// - Configuration value byte five reads 01h.
// - Configuration string index byte six reads 00h.
// - Bus power gives attributes A0h.
// - Self power gives attributes E0h only.
// - Bus power reports bus max current byte.
// - Self power reports self max current byte.
// - Max power comes from stored power fields.
// - Single interface descriptor fixed header bytes.
// - Single interface protocol 00h, 01h when multi.
// - Interface string index always 00h.
// - Single endpoint descriptor fixed bytes.
// - High-speed polling interval reads 0Ch.
// - Multi interface: alternate 01h, protocol 02h.
// - Multi descriptors present only when multi enabled.
// - Multi endpoint descriptor fixed bytes.
// - Total length 0019h or 0029h.
module hdt_desc_tables (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       power_source_select,
    input  wire logic [7:0] bus_powered_max_current,
    input  wire logic [7:0] self_powered_max_current,
    input  wire logic       multi_translator_enable,
    input  wire logic       rd_en,
    input  wire logic [5:0] rd_addr,
    output logic            rd_valid,
    output logic [7:0]      rd_data,
    output logic            rd_last,
    output logic            rd_miss
);

    logic       rst_meta;
    logic       rst_sync;
    logic [7:0] next_data;
    logic [5:0] set_end;
    logic [5:0] rel_if_stt;
    logic [5:0] rel_ep_stt;
    logic [5:0] rel_if_mtt;
    logic [5:0] rel_ep_mtt;
    logic       in_cfg;
    logic       in_if_stt;
    logic       in_ep_stt;
    logic       in_if_mtt;
    logic       in_ep_mtt;
    logic [7:0] cfg_data;
    logic [7:0] proto_stt;
    logic [7:0] max_power;
    logic [7:0] attributes;
    logic [15:0] total_len;

    // Interface descriptor byte; shared by the single and multi copies.
    function automatic logic [7:0] if_byte(input logic [5:0] rel,
                                            input logic [7:0] alt,
                                            input logic [7:0] proto);
        logic [7:0] b;
        b = hdt_pkg::BYTE_NONE;
        unique case (rel)
            hdt_pkg::IF_OFS_LEN:      b = hdt_pkg::IF_LEN;
            hdt_pkg::IF_OFS_TYPE:     b = hdt_pkg::IF_TYPE;
            hdt_pkg::IF_OFS_NUMBER:   b = hdt_pkg::IF_NUMBER;
            hdt_pkg::IF_OFS_ALT:    b = alt;
            hdt_pkg::IF_OFS_NUM_EP:   b = hdt_pkg::IF_NUM_EP;
            hdt_pkg::IF_OFS_CLASS:    b = hdt_pkg::IF_CLASS;
            hdt_pkg::IF_OFS_SUBCLASS: b = hdt_pkg::IF_SUBCLASS;
            hdt_pkg::IF_OFS_PROTO:  b = proto;
            hdt_pkg::IF_OFS_STRING: b = hdt_pkg::IF_STRING;
            default: b = hdt_pkg::BYTE_NONE;
        endcase
        return b;
    endfunction

    // Status change endpoint byte; both copies are identical.
    function automatic logic [7:0] ep_byte(input logic [5:0] rel);
        logic [7:0] b;
        b = hdt_pkg::BYTE_NONE;
        unique case (rel)
            hdt_pkg::EP_OFS_LEN:  b = hdt_pkg::EP_LEN;
            hdt_pkg::EP_OFS_TYPE: b = hdt_pkg::EP_TYPE;
            hdt_pkg::EP_OFS_ADDR: b = hdt_pkg::EP_ADDR;
            hdt_pkg::EP_OFS_ATTR: b = hdt_pkg::EP_ATTR;
            hdt_pkg::EP_OFS_MPS_LO: b = hdt_pkg::EP_MPS[7:0];
            hdt_pkg::EP_OFS_MPS_HI: b = hdt_pkg::EP_MPS[15:8];
            hdt_pkg::EP_OFS_IVAL:   b = hdt_pkg::EP_IVAL_HS;
            default: b = hdt_pkg::BYTE_NONE;
        endcase
        return b;
    endfunction

    // Reset is released through two flops so release is clean.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Power and length selection follow the live configuration fields,
    // which the loader holds stable once default or serial load is done.
    assign attributes = power_source_select
                        ? hdt_pkg::ATTR_SELF_PWR : hdt_pkg::ATTR_BUS_PWR;
    assign max_power  = power_source_select
                        ? self_powered_max_current : bus_powered_max_current;
    assign total_len  = multi_translator_enable
                        ? hdt_pkg::TOTAL_LEN_MTT : hdt_pkg::TOTAL_LEN_STT;
    assign set_end    = multi_translator_enable
                        ? hdt_pkg::SET_END_MTT : hdt_pkg::SET_END_STT;
    assign proto_stt  = multi_translator_enable
                        ? hdt_pkg::IF_PROTO_TWO : hdt_pkg::IF_PROTO_ONE;

    // Region decode of the byte address.
    assign in_cfg     = rd_addr < hdt_pkg::OFS_IF_STT;
    assign in_if_stt  = !in_cfg && rd_addr < hdt_pkg::OFS_EP_STT;
    assign in_ep_stt  = rd_addr >= hdt_pkg::OFS_EP_STT
                        && rd_addr < hdt_pkg::OFS_IF_MTT;
    assign in_if_mtt  = multi_translator_enable
                        && rd_addr >= hdt_pkg::OFS_IF_MTT
                        && rd_addr < hdt_pkg::OFS_EP_MTT;
    assign in_ep_mtt  = multi_translator_enable
                        && rd_addr >= hdt_pkg::OFS_EP_MTT
                        && rd_addr < hdt_pkg::SET_END_MTT;
    assign rel_if_stt = rd_addr - hdt_pkg::OFS_IF_STT;
    assign rel_ep_stt = rd_addr - hdt_pkg::OFS_EP_STT;
    assign rel_if_mtt = rd_addr - hdt_pkg::OFS_IF_MTT;
    assign rel_ep_mtt = rd_addr - hdt_pkg::OFS_EP_MTT;

    // Configuration descriptor bytes, length field low byte first.
    always_comb begin
        cfg_data = hdt_pkg::BYTE_NONE;
        unique case (rd_addr)
            hdt_pkg::CFG_OFS_LEN:    cfg_data = hdt_pkg::CFG_LEN;
            hdt_pkg::CFG_OFS_TYPE:   cfg_data = hdt_pkg::CFG_TYPE;
            hdt_pkg::CFG_OFS_TOT_LO: cfg_data = total_len[7:0];
            hdt_pkg::CFG_OFS_TOT_HI: cfg_data = total_len[15:8];
            hdt_pkg::CFG_OFS_NUMIF:  cfg_data = hdt_pkg::CFG_NUM_IF;
            hdt_pkg::CFG_OFS_VALUE:  cfg_data = hdt_pkg::CFG_VALUE;
            hdt_pkg::CFG_OFS_STRING: cfg_data = hdt_pkg::CFG_STRING;
            hdt_pkg::CFG_OFS_ATTR:   cfg_data = attributes;
            hdt_pkg::CFG_OFS_POWER:  cfg_data = max_power;
            default:                 cfg_data = hdt_pkg::BYTE_NONE;
        endcase
    end

    // Byte mux; addresses past the set read as zero and flag a miss.
    assign next_data =
        in_cfg    ? cfg_data :
        in_if_stt ? if_byte(rel_if_stt, hdt_pkg::IF_ALT_STT, proto_stt) :
        in_ep_stt ? ep_byte(rel_ep_stt) :
        in_if_mtt ? if_byte(rel_if_mtt, hdt_pkg::IF_ALT_MTT,
                            hdt_pkg::IF_PROTO_MTT) :
        in_ep_mtt ? ep_byte(rel_ep_mtt) :
                    hdt_pkg::BYTE_NONE;

    // Answer one cycle after the read; data holds between reads.
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            rd_valid <= 1'b0;
            rd_data  <= hdt_pkg::BYTE_NONE;
            rd_last  <= 1'b0;
            rd_miss  <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (rd_en) begin
                rd_data <= next_data;
                rd_last <= rd_addr == set_end - 6'h01;
                rd_miss <= rd_addr >= set_end;
            end
        end
    end

    cfg_value_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        rd_en && rd_addr == hdt_pkg::CFG_OFS_VALUE
        |=> rd_valid && rd_data == hdt_pkg::CFG_VALUE)
        else $error("Configuration value byte is wrong.");

    cfg_string_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        rd_en && rd_addr == hdt_pkg::CFG_OFS_STRING
        |=> rd_data == hdt_pkg::CFG_STRING)
        else $error("Configuration string index is not zero.");

    attr_bus_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        rd_en && rd_addr == hdt_pkg::CFG_OFS_ATTR && !power_source_select
        |=> rd_data == hdt_pkg::ATTR_BUS_PWR)
        else $error("Bus-powered attributes byte is wrong.");

    attr_self_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        rd_en && rd_addr == hdt_pkg::CFG_OFS_ATTR && power_source_select
        |=> rd_data == hdt_pkg::ATTR_SELF_PWR)
        else $error("Self-powered attributes byte is wrong.");

    power_bus_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        rd_en && rd_addr == hdt_pkg::CFG_OFS_POWER && !power_source_select
        |=> rd_data == $past(bus_powered_max_current))
        else $error("Bus-powered max power byte is wrong.");

    power_self_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        rd_en && rd_addr == hdt_pkg::CFG_OFS_POWER && power_source_select
        |=> rd_data == $past(self_powered_max_current))
        else $error("Self-powered max power byte is wrong.");

    if_header_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        rd_en && rd_addr == hdt_pkg::OFS_IF_STT
        ##1 rd_en && rd_addr == hdt_pkg::OFS_IF_STT + hdt_pkg::IF_OFS_TYPE
        |=> rd_data == hdt_pkg::IF_TYPE
            && $past(rd_data) == hdt_pkg::IF_LEN)
        else $error("Interface length and type bytes are wrong.");

    if_proto_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        rd_en && rd_addr == hdt_pkg::OFS_IF_STT + hdt_pkg::IF_OFS_PROTO
        |=> rd_data == ($past(multi_translator_enable)
                        ? hdt_pkg::IF_PROTO_TWO : hdt_pkg::IF_PROTO_ONE))
        else $error("Single interface protocol byte is wrong.");

    if_string_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        rd_en && (rd_addr == hdt_pkg::OFS_IF_STT + hdt_pkg::IF_OFS_STRING
                  || rd_addr == hdt_pkg::OFS_IF_MTT + hdt_pkg::IF_OFS_STRING)
        |=> rd_data == hdt_pkg::IF_STRING)
        else $error("Interface string index is not zero.");

    ep_addr_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        rd_en && rd_addr == hdt_pkg::OFS_EP_STT + hdt_pkg::EP_OFS_ADDR
        |=> rd_data == hdt_pkg::EP_ADDR)
        else $error("Endpoint address byte is wrong.");

    ep_interval_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        rd_en && rd_addr == hdt_pkg::OFS_EP_STT + hdt_pkg::EP_OFS_IVAL
        |=> rd_data == hdt_pkg::EP_IVAL_HS)
        else $error("Polling interval byte is wrong.");

    mtt_iface_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        multi_translator_enable && rd_en
        && rd_addr == hdt_pkg::OFS_IF_MTT + hdt_pkg::IF_OFS_ALT
        |=> rd_data == hdt_pkg::IF_ALT_MTT)
        else $error("Multi interface alternate setting is wrong.");

    mtt_hidden_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        !multi_translator_enable && rd_en && rd_addr >= hdt_pkg::OFS_IF_MTT
        |=> rd_miss && rd_data == hdt_pkg::BYTE_NONE)
        else $error("Multi descriptors visible while disabled.");

    mtt_ep_attr_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        multi_translator_enable && rd_en
        && rd_addr == hdt_pkg::OFS_EP_MTT + hdt_pkg::EP_OFS_ATTR
        |=> rd_data == hdt_pkg::EP_ATTR && !rd_miss)
        else $error("Multi endpoint attributes byte is wrong.");

    total_len_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        rd_en && rd_addr == hdt_pkg::CFG_OFS_TOT_LO
        |=> rd_data == ($past(multi_translator_enable)
                        ? hdt_pkg::TOTAL_LEN_MTT[7:0]
                        : hdt_pkg::TOTAL_LEN_STT[7:0]))
        else $error("Total length low byte is wrong.");

    mps_order_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        rd_en && rd_addr == hdt_pkg::OFS_EP_STT + hdt_pkg::EP_OFS_MPS_LO
        ##1 rd_en && rd_addr == hdt_pkg::OFS_EP_STT + hdt_pkg::EP_OFS_MPS_HI
        |=> rd_data == hdt_pkg::EP_MPS[15:8]
            && $past(rd_data) == hdt_pkg::EP_MPS[7:0])
        else $error("Max packet size byte order is wrong.");

    if_class_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        rd_en && rd_addr == hdt_pkg::OFS_IF_STT + hdt_pkg::IF_OFS_CLASS
        |=> rd_data == hdt_pkg::IF_CLASS)
        else $error("Interface class byte is wrong.");

    ep_header_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        rd_en && rd_addr == hdt_pkg::OFS_EP_STT + hdt_pkg::EP_OFS_LEN
        |=> rd_data == hdt_pkg::EP_LEN)
        else $error("Endpoint length byte is wrong.");

    mtt_proto_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        multi_translator_enable && rd_en
        && rd_addr == hdt_pkg::OFS_IF_MTT + hdt_pkg::IF_OFS_PROTO
        |=> rd_data == hdt_pkg::IF_PROTO_MTT)
        else $error("Multi interface protocol byte is wrong.");

    mtt_shown_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        multi_translator_enable && rd_en && rd_addr == hdt_pkg::OFS_IF_MTT
        |=> !rd_miss && rd_data == hdt_pkg::IF_LEN)
        else $error("Multi interface hidden while enabled.");

    mtt_ep_ival_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        multi_translator_enable && rd_en
        && rd_addr == hdt_pkg::OFS_EP_MTT + hdt_pkg::EP_OFS_IVAL
        |=> rd_data == hdt_pkg::EP_IVAL_HS)
        else $error("Multi endpoint polling interval is wrong.");

    total_hi_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        rd_en && rd_addr == hdt_pkg::CFG_OFS_TOT_HI
        |=> rd_data == ($past(multi_translator_enable)
                        ? hdt_pkg::TOTAL_LEN_MTT[15:8]
                        : hdt_pkg::TOTAL_LEN_STT[15:8]))
        else $error("Total length high byte is wrong.");

    set_last_a: assert property (
        @(posedge clk) disable iff (!rst_sync)
        rd_en && rd_addr + 6'h01 == (multi_translator_enable
                                     ? hdt_pkg::SET_END_MTT
                                     : hdt_pkg::SET_END_STT)
        |=> rd_last && !rd_miss)
        else $error("Last byte of the set is not flagged.");

endmodule // hdt_desc_tables

// ---- hdt_host_model.sv ----
// Upstream host that fetches descriptor bytes from the table block.
module hdt_host_model (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [5:0] first,
    input  wire logic [6:0] count,
    input  wire logic       gap,
    output logic            rd_en,
    output logic [5:0]      rd_addr,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_last,
    input  wire logic       rd_miss,
    output logic            busy,
    output logic [7:0]      got [64],
    output logic [63:0]     got_last,
    output logic [63:0]     got_miss,
    output logic [7:0]      nvalid
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [5:0] pend;

    // Issue a burst; the address is scrambled when idle so stale values
    // never pass for a real request.
    initial begin
        rd_en = 1'b0;
        rd_addr = 6'h00;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (go === 1'b1) begin
                busy = 1'b1;
                for (int i = 0; i < count; i++) begin
                    @(negedge clk);
                    rd_en = 1'b1;
                    rd_addr = first + i[5:0];
                    if (gap) begin
                        @(negedge clk);
                        rd_en = 1'b0;
                        rd_addr = ~rd_addr;
                    end
                end
                @(negedge clk);
                rd_en = 1'b0;
                rd_addr = ~rd_addr;
                repeat (2) @(posedge clk);
                busy = 1'b0;
            end
        end
    end

    // Each answer belongs to the request taken one edge earlier.
    always @(posedge clk) begin
        if (rd_valid === 1'b1) begin
            got[pend] <= rd_data;
            got_last[pend] <= rd_last;
            got_miss[pend] <= rd_miss;
        end
        if (go === 1'b1) nvalid <= 8'h00;
        else if (rd_valid === 1'b1) nvalid <= nvalid + 8'h01;
        if (rd_en) pend <= rd_addr;
    end
endmodule // hdt_host_model

// ---- hdt_desc_tables_test.sv ----
module hdt_desc_tables_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk, nrst, pss, mte, go, gap, busy;
    logic        rd_en, rd_valid, rd_last, rd_miss;
    logic [7:0]  bpc, spc, rd_data, nvalid;
    logic [5:0]  rd_addr, first;
    logic [6:0]  count;
    logic [7:0]  got [64];
    logic [63:0] got_last, got_miss;
    int          fails = 0;
    int          num_checks = 0;

    hdt_desc_tables dut (.clk(clk), .nrst(nrst), .power_source_select(pss),
        .bus_powered_max_current(bpc), .self_powered_max_current(spc),
        .multi_translator_enable(mte), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_valid(rd_valid), .rd_data(rd_data), .rd_last(rd_last),
        .rd_miss(rd_miss));

    hdt_host_model host (.clk(clk), .go(go), .first(first), .count(count),
        .gap(gap), .rd_en(rd_en), .rd_addr(rd_addr), .rd_valid(rd_valid),
        .rd_data(rd_data), .rd_last(rd_last), .rd_miss(rd_miss),
        .busy(busy), .got(got), .got_last(got_last), .got_miss(got_miss),
        .nvalid(nvalid));

    // Clock at 125 MHz.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Expected byte at an address, worked out from the descriptor layout.
    function automatic logic [7:0] exp_byte(input int a, input logic ps,
        input logic mt, input logic [7:0] bp, input logic [7:0] sp);
        int o;
        logic hi;
        o = 0;
        hi = (a >= 25);
        if (a >= (mt ? 41 : 25)) return 8'h00;
        if (a < 9) begin
            case (a)
                0: return 8'h09;
                1: return 8'h07;
                2: return mt ? 8'h29 : 8'h19;
                3, 6: return 8'h00;
                7: return ps ? 8'he0 : 8'ha0;
                8: return ps ? sp : bp;
                default: return 8'h01;
            endcase
        end
        o = hi ? a - 25 : a - 9;
        if (o < 9) begin
            case (o)
                0: return 8'h09;
                1: return 8'h04;
                3: return hi ? 8'h01 : 8'h00;
                4: return 8'h01;
                5: return 8'h09;
                7: return hi ? 8'h02 : (mt ? 8'h01 : 8'h00);
                default: return 8'h00;
            endcase
        end
        case (o - 9)
            0: return 8'h07;
            1: return 8'h05;
            2: return 8'h81;
            3: return 8'h03;
            4: return 8'h01;
            6: return 8'h0c;
            default: return 8'h00;
        endcase
    endfunction

    task automatic check_byte(input logic [7:0] v, input logic [7:0] e,
        input string what);
        num_checks++;
        if (v !== e) begin
            fails++;
            $display("wrong value at %0t: %s got %h want %h",
                     $time, what, v, e);
        end
    endtask

    task automatic check_flag(input logic v, input logic e, input string what);
        num_checks++;
        if (v !== e) begin
            fails++;
            $display("wrong value at %0t: %s got %b want %b",
                     $time, what, v, e);
        end
    endtask

    // Closing task, shared by the main sequence and the watchdog.
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Reads the whole address space, the part past the set end included.
    task automatic run_cfg(input logic ps, input logic mt,
        input logic [7:0] bp,
        input logic [7:0] sp, input logic g);
        int t;
        int e;
        pss = ps;
        mte = mt;
        bpc = bp;
        spc = sp;
        first = 6'h00;
        count = 7'd64;
        gap = g;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        t = 0;
        while (busy === 1'b1 && t < 1000) begin
            @(negedge clk);
            t++;
        end
        check_flag(t < 1000, 1'b1, "burst finished");
        check_byte(nvalid, 8'd64, "answer count");
        e = mt ? 41 : 25;
        for (int a = 0; a < 64; a++) begin
            check_byte(got[a], exp_byte(a, ps, mt, bp, sp), "byte");
            check_flag(got_miss[a], a >= e, "miss flag");
            check_flag(got_last[a], a == e - 1, "last flag");
        end
        // Spot checks of single fields, each against its own rule value.
        check_byte(got[5], 8'h01, "config value");
        check_byte(got[6], 8'h00, "config string");
        check_byte(got[7], ps ? 8'he0 : 8'ha0, "attributes");
        check_byte(got[8], ps ? sp : bp, "max power");
        check_byte(got[16], mt ? 8'h01 : 8'h00, "single protocol");
        check_byte(got[17], 8'h00, "interface string");
        check_byte(got[20], 8'h81, "endpoint address");
        check_byte(got[24], 8'h0c, "polling interval");
        check_byte(got[28], mt ? 8'h01 : 8'h00, "multi alternate");
        check_byte(got[37], mt ? 8'h03 : 8'h00, "multi attributes");
        check_byte(got[2], mt ? 8'h29 : 8'h19, "total length");
        check_byte(got[22], 8'h01, "max packet low");
        check_byte(got[23], 8'h00, "max packet high");
        $display("test done: power %0b multi %0b gap %0b", ps, mt, g);
    endtask

    // Cuts a hang short; the tests need well under 2000 cycles.
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        $display("wrong value at %0t: watchdog expired", $time);
        test_done();
    end

    // Main sequence; inputs change on the falling edge only.
    initial begin
        nrst = 1'b0;
        {pss, mte, go, gap} = 4'h0;
        {bpc, spc, first, count} = '0;
        repeat (8) @(negedge clk);
        check_flag(rd_valid, 1'b0, "valid in reset");
        check_byte(rd_data, 8'h00, "data in reset");
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        run_cfg(1'b0, 1'b0, 8'h32, 8'hc8, 1'b0);
        run_cfg(1'b1, 1'b0, 8'h32, 8'hc8, 1'b0);
        run_cfg(1'b0, 1'b1, 8'hfa, 8'h05, 1'b1);
        run_cfg(1'b1, 1'b1, 8'h01, 8'hfe, 1'b0);
        test_done();
    end
endmodule // hdt_desc_tables_test
